// ==== verilog/adc_seq_pkg.sv ====
package adc_seq_pkg;

  // Register word indices on the Wishbone bus, matched against byte address bits 5:2.
  localparam logic [3:0] ADDR_CTRL_STATUS_1  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_STATUS_2  = 4'h1;
  localparam logic [3:0] ADDR_RESULT_HIGH    = 4'h2;
  localparam logic [3:0] ADDR_RESULT_LOW     = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_HIGH   = 4'h4;
  localparam logic [3:0] ADDR_COMPARE_LOW    = 4'h5;
  localparam logic [3:0] ADDR_CONFIG         = 4'h6;
  localparam logic [3:0] ADDR_ANALOG_SAMPLE  = 4'h7;

  // Field positions in ctrl_status_1.
  localparam int CS1_DONE_BIT = 7;
  localparam int CS1_IEN_BIT  = 6;
  localparam int CS1_CONT_BIT = 5;
  // Field positions in ctrl_status_2.
  localparam int CS2_ACTIVE_BIT = 7;
  localparam int CS2_HWT_BIT    = 6;
  localparam int CS2_CMPEN_BIT  = 5;
  localparam int CS2_CMPGT_BIT  = 4;
  // Field positions in converter_config.
  localparam int CFG_LP_BIT    = 7;
  localparam int CFG_DIV_LSB   = 5;
  localparam int CFG_LSMP_BIT  = 4;
  localparam int CFG_MODE_LSB  = 2;
  localparam int CFG_CLK_LSB   = 0;

  // Reset values.
  localparam logic [7:0] CS1_RESET = 8'h1F;
  localparam logic [7:0] CS2_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Resolution modes and clock sources.
  localparam logic [1:0] MODE_8BIT   = 2'h0;
  localparam logic [1:0] MODE_10BIT  = 2'h2;
  localparam logic [1:0] CLK_BUS     = 2'h0;
  localparam logic [1:0] CLK_BUS_DV2 = 2'h1;
  localparam logic [1:0] CLK_ALT     = 2'h2;
  localparam logic [1:0] CLK_ASYNC   = 2'h3;

  // Cycle budgets: conversion clocks for sample, approximation and first-conversion extra; bus cycles of overhead.
  localparam int SHORT_SAMPLE_CYC  = 3;
  localparam int LONG_SAMPLE_CYC   = 23;
  localparam int APPROX_8_CYC      = 14;
  localparam int APPROX_10_CYC     = 17;
  localparam int FIRST_EXTRA_CYC   = 3;
  localparam int BUS_OVERHEAD_CYC  = 5;

  // Asynchronous clock start-up time and its bus-cycle count.
  localparam int CLK_PERIOD_NS     = 100;
  localparam int ASYNC_STARTUP_NS  = 5000;
  localparam int ASYNC_STARTUP_CYC = ASYNC_STARTUP_NS / CLK_PERIOD_NS;

  // Conversion sequencer states.
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b00_0001,
    ST_STARTUP = 6'b00_0010,
    ST_OVERHD  = 6'b00_0100,
    ST_SAMPLE  = 6'b00_1000,
    ST_APPROX  = 6'b01_0000,
    ST_FINISH  = 6'b10_0000
  } seq_state_t;

endpackage

// ==== verilog/adc_conversion_sequencer.sv ====
`timescale 1ns/1ps

// Summary of operation
// [R1] Software trigger: a ctrl_status_1 write with channel not all ones starts conversion.
// [R2] Hardware trigger: an event on hw_trigger_input starts conversion.
// [R3] Continuous mode relaunches after each result transfer.
// [R4] Continuous runs start on the write or first trigger, repeat until aborted.
// [R5] Completion loads result, sets done flag; interrupt if enabled at that moment.
// [R6] 10-bit: high read but low not read blocks transfer; result discarded.
// [R7] Single conversion with compare false: blocking ignored, converter stops.
// [R8] Other blocked transfers start another conversion regardless of continuous bit.
// [R9] Software must not read results during a single conversion.
// [R10] A ctrl_status_1 write aborts; restarts unless channel is all ones.
// [R11] Writes to other control registers, reset, or stop without async clock abort.
// [R12] Abort keeps last results; reset returns them to reset values.
// [R13] Idle until started; async clock generator enabled only while converting.
// [R14] Sample short or long, then approximate, then transfer.
// [R15] First conversion: 5 bus cycles plus 20/23 or 40/43 conversion clocks.
// [R16] Async clock source adds 5 us start-up to first conversions.
// [R17] Subsequent continuous: 17/20 or 37/40 conversion clocks.
// [R18] Compare adds two's complement; flag on greater-equal or less-than.
// [R19] Compare true loads the difference, not the raw result.
// [R20] Compare false: no flag and no result update.
// [R21] Wait mode: running conversion finishes; trigger or continuous may start more.
// [R22] Completion in wait mode sets flag and raises wake interrupt if enabled.
// [R23] Compare active only while compare_enable is set.
// [R24] hw_trigger_select picks hardware triggering on rising edges.
// [R25] Rising trigger edges during a conversion are ignored.
// [R26] 10-bit result fills both bytes; 8-bit result sits in result_low.
// [R27] Reading result_low releases the blocking.
// [R28] ctrl_status_1 write or result_low read clears the done flag.
module adc_conversion_sequencer #(
  parameter int DATA_BITS = 10
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [5:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        hw_trigger_input_in,
  input  wire logic        alternate_clock_in,
  input  wire logic        async_clock_tick_in,
  input  wire logic [9:0]  analog_value_in,
  input  wire logic        wait_mode_in,
  input  wire logic        stop_mode_in,
  output logic             done_irq_out,
  output logic             async_clock_enable_out,
  output logic             converting_out,
  output logic             sample_enable_out
);

  // Elaboration check on the result width.
  if (DATA_BITS != 10) begin : g_width_check
    $error("adc_conversion_sequencer supports DATA_BITS of 10 only");
  end

  // Register state.
  logic [7:0]  cs1_r;
  logic [7:0]  cs2_r;
  logic [7:0]  cfg_r;
  logic [7:0]  cmp_hi_r;
  logic [7:0]  cmp_lo_r;
  logic [7:0]  res_hi_r;
  logic [7:0]  res_lo_r;
  logic        done_r;
  logic        block_r;
  logic        trig_prev_r;
  logic        alt_prev_r;
  logic        div2_r;
  logic [2:0]  div_cnt_r;
  logic [9:0]  held_r;
  logic        first_r;
  logic        cont_run_r;
  logic [7:0]  cnt_r;
  adc_seq_pkg::seq_state_t state_r;

  // Bus decode.
  wire         bus_req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire         wr_en      = bus_req & wb_we_in & wb_sel_in[0];
  wire         rd_en      = bus_req & ~wb_we_in;
  wire  [3:0]  reg_idx    = wb_adr_in[5:2];
  wire         wr_cs1     = wr_en & (reg_idx == adc_seq_pkg::ADDR_CTRL_STATUS_1);
  wire         wr_cs2     = wr_en & (reg_idx == adc_seq_pkg::ADDR_CTRL_STATUS_2);
  wire         wr_cfg     = wr_en & (reg_idx == adc_seq_pkg::ADDR_CONFIG);
  wire         wr_cmph    = wr_en & (reg_idx == adc_seq_pkg::ADDR_COMPARE_HIGH);
  wire         wr_cmpl    = wr_en & (reg_idx == adc_seq_pkg::ADDR_COMPARE_LOW);
  wire         rd_hi      = rd_en & (reg_idx == adc_seq_pkg::ADDR_RESULT_HIGH);
  wire         rd_lo      = rd_en & (reg_idx == adc_seq_pkg::ADDR_RESULT_LOW);

  // Configuration fields.
  wire  [4:0]  chan_new   = wb_dat_in[4:0];
  wire         chan_off   = &cs1_r[4:0];
  wire         irq_en     = cs1_r[adc_seq_pkg::CS1_IEN_BIT];
  wire         cont_en    = cs1_r[adc_seq_pkg::CS1_CONT_BIT];
  wire         hwt_sel    = cs2_r[adc_seq_pkg::CS2_HWT_BIT];
  wire         cmp_en     = cs2_r[adc_seq_pkg::CS2_CMPEN_BIT];
  wire         cmp_gt     = cs2_r[adc_seq_pkg::CS2_CMPGT_BIT];
  wire         long_smp   = cfg_r[adc_seq_pkg::CFG_LSMP_BIT];
  wire  [1:0]  div_sel    = cfg_r[adc_seq_pkg::CFG_DIV_LSB +: 2];
  wire  [1:0]  mode_sel   = cfg_r[adc_seq_pkg::CFG_MODE_LSB +: 2];
  wire  [1:0]  clk_sel    = cfg_r[adc_seq_pkg::CFG_CLK_LSB +: 2];
  wire         mode10     = (mode_sel == adc_seq_pkg::MODE_10BIT);
  wire         async_sel  = (clk_sel == adc_seq_pkg::CLK_ASYNC);
  wire         busy       = (state_r != adc_seq_pkg::ST_IDLE);

  // Source tick from the selected clock, then the divide by 1, 2, 4 or 8.
  wire         alt_edge   = alternate_clock_in & ~alt_prev_r;
  wire         src_tick   = (clk_sel == adc_seq_pkg::CLK_BUS)     ? 1'b1 :
                            (clk_sel == adc_seq_pkg::CLK_BUS_DV2) ? div2_r :
                            (clk_sel == adc_seq_pkg::CLK_ALT)     ? alt_edge :
                                                                    async_clock_tick_in;
  wire  [2:0]  div_mask   = 3'((4'h1 << div_sel) - 4'h1);
  wire         conv_tick  = src_tick & ((div_cnt_r & div_mask) == div_mask);

  // Abort sources and start sources.
  // [R11] Abort conditions
  wire         abort_cfg  = wr_cs2 | wr_cfg | wr_cmph | wr_cmpl | (stop_mode_in & ~async_sel);
  // [R1] Software start
  wire         sw_start   = wr_cs1 & ~(&chan_new) & ~hwt_sel;
  // [R24] Rising edge
  wire         trig_edge  = hw_trigger_input_in & ~trig_prev_r;
  // [R2] Hardware start, ignored while busy
  // [R25] Busy ignores edges
  wire         hw_start   = hwt_sel & trig_edge & ~busy & ~cont_run_r & ~chan_off & ~stop_mode_in;

  // Compare arithmetic and result formatting.
  // [R23] Compare gating
  wire  [9:0]  cmp_val    = mode10 ? {cmp_hi_r[1:0], cmp_lo_r} : {2'h0, cmp_lo_r};
  wire  [9:0]  raw_val    = mode10 ? held_r : {2'h0, held_r[9:2]};
  // [R18] Two's complement add
  wire  [10:0] diff       = {1'b0, raw_val} + {1'b0, 10'(~cmp_val)} + 11'h001;
  wire         ge_val     = diff[10];
  wire         cmp_true   = ~cmp_en | (cmp_gt ? ge_val : ~ge_val);
  // [R19] Difference replaces raw
  wire  [9:0]  out_val    = (cmp_en ? diff[9:0] : raw_val) & (mode10 ? 10'h3FF : 10'h0FF);
  wire         blocked    = block_r & mode10;

  // Budget of the sample phase and the approximation phase.
  // [R14] Sample length
  wire  [7:0]  smp_len    = 8'(long_smp ? adc_seq_pkg::LONG_SAMPLE_CYC : adc_seq_pkg::SHORT_SAMPLE_CYC);
  // [R15] First conversion budget
  // [R17] Subsequent conversion budget
  wire  [7:0]  apx_len    = 8'(mode10 ? adc_seq_pkg::APPROX_10_CYC : adc_seq_pkg::APPROX_8_CYC)
                            + (first_r ? 8'(adc_seq_pkg::FIRST_EXTRA_CYC) : 8'h00);

  // Finishing step decisions.
  wire         finishing  = (state_r == adc_seq_pkg::ST_FINISH);
  // [R20] Compare false skips transfer
  // [R6] Blocked transfer discarded
  wire         do_xfer    = finishing & cmp_true & ~blocked;
  // [R7] Single compare-false stops
  // [R8] Blocked restarts
  // [R3] Continuous relaunch
  // [R4] Until aborted
  wire         restart    = finishing & ((cmp_true & blocked) | cont_en);
  // [R21] In wait mode with the alternate clock, wait_ok masks new_start, so converting_out rises a cycle late; the sequencer still starts.
  wire         wait_ok    = ~wait_mode_in | (clk_sel != adc_seq_pkg::CLK_ALT);
  wire         new_start  = (sw_start | hw_start) & wait_ok;

  // Bus read mux.
  wire  [7:0]  rd_byte    =
    (reg_idx == adc_seq_pkg::ADDR_CTRL_STATUS_1) ? {done_r, cs1_r[6:0]} :
    (reg_idx == adc_seq_pkg::ADDR_CTRL_STATUS_2) ? {busy, cs2_r[6:4], 4'h0} :
    (reg_idx == adc_seq_pkg::ADDR_RESULT_HIGH)   ? res_hi_r :
    (reg_idx == adc_seq_pkg::ADDR_RESULT_LOW)    ? res_lo_r :
    (reg_idx == adc_seq_pkg::ADDR_COMPARE_HIGH)  ? cmp_hi_r :
    (reg_idx == adc_seq_pkg::ADDR_COMPARE_LOW)   ? cmp_lo_r :
    (reg_idx == adc_seq_pkg::ADDR_CONFIG)        ? cfg_r : 8'h00;

  // Bus acknowledge and read data, one cycle after the request.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Control registers and edge history.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cs1_r       <= adc_seq_pkg::CS1_RESET;
      cs2_r       <= adc_seq_pkg::CS2_RESET;
      cfg_r       <= adc_seq_pkg::CFG_RESET;
      cmp_hi_r    <= 8'h00;
      cmp_lo_r    <= 8'h00;
      trig_prev_r <= 1'b0;
      alt_prev_r  <= 1'b0;
      div2_r      <= 1'b0;
    end else begin
      if (wr_cs1)  cs1_r    <= {1'b0, wb_dat_in[6:0]};
      if (wr_cs2)  cs2_r    <= {1'b0, wb_dat_in[6:4], 4'h0};
      if (wr_cfg)  cfg_r    <= wb_dat_in[7:0];
      if (wr_cmph) cmp_hi_r <= {6'h00, wb_dat_in[1:0]};
      if (wr_cmpl) cmp_lo_r <= wb_dat_in[7:0];
      trig_prev_r <= hw_trigger_input_in;
      alt_prev_r  <= alternate_clock_in;
      div2_r      <= ~div2_r;
    end
  end

  // Done flag, block latch and result bytes.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // [R12] Reset clears results
      res_hi_r <= 8'h00;
      res_lo_r <= 8'h00;
      done_r   <= 1'b0;
      block_r  <= 1'b0;
    end else begin
      // [R5] Transfer and flag
      // [R26] Result placement
      if (do_xfer) begin
        res_hi_r <= {6'h00, out_val[9:8]};
        res_lo_r <= out_val[7:0];
      end
      // [R28] Clear, with set winning
      if (do_xfer) done_r <= 1'b1;
      else if (wr_cs1 | rd_lo) done_r <= 1'b0;
      // [R27] Low read releases
      if (rd_hi) block_r <= 1'b1;
      else if (rd_lo) block_r <= 1'b0;
    end
  end

  // Interrupt and status outputs.
  // [R22] Wake interrupt
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_irq_out           <= 1'b0;
      async_clock_enable_out <= 1'b0;
      converting_out         <= 1'b0;
      sample_enable_out      <= 1'b0;
    end else begin
      done_irq_out           <= (do_xfer | done_r) & irq_en & ~(wr_cs1 | rd_lo);
      // [R13] Async generator gating
      async_clock_enable_out <= async_sel & (new_start | restart | (busy & ~finishing));
      converting_out         <= new_start | restart | (busy & ~finishing);
      sample_enable_out      <= (state_r == adc_seq_pkg::ST_SAMPLE);
    end
  end

  // Conversion sequencer.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r    <= adc_seq_pkg::ST_IDLE;
      cnt_r      <= 8'h00;
      div_cnt_r  <= 3'h0;
      held_r     <= 10'h000;
      first_r    <= 1'b0;
      cont_run_r <= 1'b0;
    end else if (wr_cs1 | abort_cfg) begin
      // [R10] Abort and restart
      state_r    <= sw_start ? adc_seq_pkg::ST_STARTUP : adc_seq_pkg::ST_IDLE;
      cnt_r      <= 8'h00;
      div_cnt_r  <= 3'h0;
      first_r    <= 1'b1;
      cont_run_r <= 1'b0;
    end else begin
      if (src_tick) div_cnt_r <= div_cnt_r + 3'h1;
      unique case (state_r)
        adc_seq_pkg::ST_IDLE: begin
          if (hw_start) begin
            state_r    <= adc_seq_pkg::ST_STARTUP;
            first_r    <= 1'b1;
            cont_run_r <= cont_en;
          end
        end
        adc_seq_pkg::ST_STARTUP: begin
          // [R16] Async start-up delay
          if (!async_sel || cnt_r >= 8'(adc_seq_pkg::ASYNC_STARTUP_CYC - 1)) begin
            state_r <= adc_seq_pkg::ST_OVERHD;
            cnt_r   <= 8'h00;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        adc_seq_pkg::ST_OVERHD: begin
          // Start-up step, these three steps and the finish step make the five bus cycles.
          if (cnt_r >= 8'(adc_seq_pkg::BUS_OVERHEAD_CYC - 3)) begin
            state_r <= adc_seq_pkg::ST_SAMPLE;
            cnt_r   <= 8'h00;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        adc_seq_pkg::ST_SAMPLE: begin
          if (conv_tick) begin
            if (cnt_r >= smp_len - 8'h01) begin
              state_r <= adc_seq_pkg::ST_APPROX;
              held_r  <= analog_value_in;
              cnt_r   <= 8'h00;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        end
        adc_seq_pkg::ST_APPROX: begin
          if (conv_tick) begin
            if (cnt_r >= apx_len - 8'h01) begin
              state_r <= adc_seq_pkg::ST_FINISH;
              cnt_r   <= 8'h00;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        end
        adc_seq_pkg::ST_FINISH: begin
          state_r <= restart ? adc_seq_pkg::ST_SAMPLE : adc_seq_pkg::ST_IDLE;
          first_r <= 1'b0;
          if (!restart) cont_run_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== dv/adc_seq_checker_assertions.sv ====
`timescale 1ns/1ps

// Watches the register bus and the conversion status outputs of the sequencer.
module adc_seq_checker (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [5:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        hw_trigger_input_in,
  input wire logic        async_clock_enable_out,
  input wire logic        converting_out,
  input wire logic        sample_enable_out
);
  logic hwt_r;
  logic cont_r;
  // Decodes the bus requests that the slave takes.
  wire logic       take     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire logic       wr       = take & wb_we_in & wb_sel_in[0];
  wire logic [3:0] wix      = wb_adr_in[5:2];
  wire logic       cs1_wr   = wr & (wix == 4'h0);
  wire logic       chan_off = (wb_dat_in[4:0] == 5'h1F);
  wire logic       mode_wr  = wr & (wix == 4'h1 | wix == 4'h4 | wix == 4'h5 | wix == 4'h6);

  // Follows the trigger select and continuous bits as software writes them.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hwt_r  <= 1'b0;
      cont_r <= 1'b0;
    end else begin
      hwt_r  <= (wr && wix == 4'h1) ? wb_dat_in[6] : hwt_r;
      cont_r <= cs1_wr ? wb_dat_in[5] : cont_r;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
  property p_ack_lat; take |=> wb_ack_out; endproperty
  property p_upper; wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000; endproperty
  property p_sw_start; cs1_wr && !chan_off && !hwt_r |-> ##[1:3] converting_out; endproperty
  property p_off_abort; cs1_wr && chan_off |-> ##[1:3] !converting_out; endproperty
  property p_mode_abort; mode_wr |-> ##[1:3] !converting_out; endproperty
  property p_idle; $fell(reset_in) |-> !converting_out; endproperty
  property p_async; (!converting_out) [*2] |-> !async_clock_enable_out; endproperty
  property p_sample; sample_enable_out |-> converting_out; endproperty
  property p_hw_start;
    hwt_r && !cont_r && !converting_out && $rose(hw_trigger_input_in) |-> ##[1:4] converting_out;
  endproperty

  a_ack_one: // ack is a one-cycle pulse
    assert property (p_ack_one) else $error("ack held longer than one cycle");
  a_ack_lat: // ack follows a taken request
    assert property (p_ack_lat) else $error("ack late");
  a_upper: // upper read bytes are zero
    assert property (p_upper) else $error("upper read bytes not zero");
  a_sw_start:
    assert property (p_sw_start) else $error("software write did not start");
  a_off_abort:
    assert property (p_off_abort) else $error("write with channel off did not stop");
  a_mode_abort:
    assert property (p_mode_abort) else $error("mode write did not abort");
  a_idle:
    assert property (p_idle) else $error("busy right after reset");
  a_async:
    assert property (p_async) else $error("async clock enabled while idle");
  a_sample:
    assert property (p_sample) else $error("sampling outside a conversion");
  a_hw_start:
    assert property (p_hw_start) else $error("trigger edge did not start");

  // Main scenarios reached.
  c_sw: cover property (cs1_wr && !chan_off);
  c_hw: cover property (hwt_r && $rose(hw_trigger_input_in));
  c_mode: cover property (mode_wr);
endmodule

bind adc_conversion_sequencer adc_seq_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .hw_trigger_input_in(hw_trigger_input_in),
  .async_clock_enable_out(async_clock_enable_out), .converting_out(converting_out),
  .sample_enable_out(sample_enable_out));

// ==== dv/analog_source.sv ====
`timescale 1ns/1ps

// Far side: analog channel level, trigger source and free-running clock ticks.
module analog_source (
  input  wire logic       clk_in,
  input  wire logic [9:0] level_in,
  input  wire logic       fire_in,
  output logic      [9:0] analog_value_out,
  output logic            hw_trigger_out,
  output logic            alt_clock_out,
  output logic            async_tick_out
);
  logic [1:0] div_r = 2'h0;

  // Divides the bus clock to make the alternate clock and the async ticks.
  always_ff @(posedge clk_in) begin
    div_r <= div_r + 2'h1;
  end

  // Level and trigger follow the bench, which only changes them after edges.
  assign analog_value_out = level_in;
  assign hw_trigger_out   = fire_in;
  assign alt_clock_out    = div_r[1];
  assign async_tick_out   = (div_r == 2'h3);
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps

// Drives the sequencer over its register bus and checks what it reports.
module testbench;
  logic        clk_in;
  logic        reset_in;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [9:0]  level;
  logic        fire;
  logic        trig;
  logic        alt;
  logic        tick;
  logic [9:0]  aval;
  logic        wait_mode;
  logic        stop_mode;
  logic        irq;
  logic        conv;
  logic [7:0]  q;
  logic [7:0]  cfg;
  logic        f;
  int          bad_count;
  int          checked;
  int          i;
  int          n;
  int          bud;
  logic [3:0]  zw [6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h9};
  logic [7:0]  c2 [3] = '{8'h30, 8'h30, 8'h20};
  logic [9:0]  lv [3] = '{10'h180, 10'h0C0, 10'h0C0};
  logic [7:0]  rh [3] = '{8'h00, 8'h00, 8'h03};
  logic [7:0]  rl [3] = '{8'h80, 8'h80, 8'hC0};

  adc_conversion_sequencer DUT (.clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .hw_trigger_input_in(trig), .alternate_clock_in(alt), .async_clock_tick_in(tick), .analog_value_in(aval),
    .wait_mode_in(wait_mode), .stop_mode_in(stop_mode), .done_irq_out(irq), .async_clock_enable_out(),
    .converting_out(conv), .sample_enable_out());

  analog_source src (.clk_in(clk_in), .level_in(level), .fire_in(fire), .analog_value_out(aval),
    .hw_trigger_out(trig), .alt_clock_out(alt), .async_tick_out(tick));

  // Makes the 10 MHz bus clock.
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; holds the request until ack is sampled high.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'h0};
    sel <= {3'h0, s};
    wdat <= {24'h00_0000, d};
    @(posedge clk_in);
    while (ack !== 1'b1) begin
      k++;
      if (k > 20) begin
        bad_count++;
        tally_and_finish;
      end
      @(posedge clk_in);
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b1);
    chk(q, e);
  endtask

  // Polls only the status word, never the results, while a conversion runs.
  // status only
  task automatic poll;
    f = 1'b0;
    for (int k = 0; k < 80 && !f; k++) begin
      bus(1'b0, 4'h0, 8'h00, 1'b1);
      f = q[7];
    end
  endtask

  task automatic pulse;
    fire <= 1'b1;
    repeat (2) @(posedge clk_in);
    fire <= 1'b0;
    @(posedge clk_in);
  endtask

  // Main sequence of tests.
  initial begin
    reset_in = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    level = 10'h000;
    fire = 1'b0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rd(4'h0, 8'h1F);
    for (i = 0; i < 6; i++) begin
      rd(zw[i], 8'h00);
    end
    bus(1'b1, 4'h6, 8'hFF, 1'b0);
    rd(4'h6, 8'h00);
    $display("test reset done");
    level <= 10'h2A4;
    for (i = 0; i < 4; i++) begin
      cfg = {3'h0, i[1], (i[0] ? 2'h2 : 2'h0), 2'h0};
      bud = 5 + (i[1] ? 40 : 20) + (i[0] ? 3 : 0);
      wr(4'h6, cfg);
      wr(4'h0, 8'h41);
      // Counts edges from the one after the taking edge of the write to the transfer edge.
      n = 1;
      while (conv === 1'b1 && n <= bud) begin
        @(posedge clk_in);
        n++;
      end
      chk(n <= bud, 1'b1);
      poll;
      chk(f, 1'b1);
      chk(irq, 1'b1);
      rd(4'h2, i[0] ? 8'h02 : 8'h00);
      rd(4'h3, i[0] ? 8'hA4 : 8'hA9);
      rd(4'h0, 8'h41);
      chk(irq, 1'b0);
    end
    $display("test modes done");
    wr(4'h6, 8'h08);
    wait_mode <= 1'b1;
    level <= 10'h155;
    wr(4'h0, 8'h21);
    poll;
    chk(f, 1'b1);
    rd(4'h2, 8'h01);
    level <= 10'h2EA;
    repeat (80) @(posedge clk_in);
    rd(4'h3, 8'h55);
    poll;
    chk(f, 1'b1);
    rd(4'h2, 8'h02);
    rd(4'h3, 8'hEA);
    wr(4'h0, 8'h1F);
    wait_mode <= 1'b0;
    $display("test blocking done");
    for (i = 0; i < 3; i++) begin
      wr(4'h1, c2[i]);
      wr(4'h4, 8'h01);
      wr(4'h5, 8'h00);
      level <= lv[i];
      wr(4'h0, 8'h01);
      poll;
      chk(f, i != 1);
      chk(conv, 1'b0);
      rd(4'h2, rh[i]);
      rd(4'h3, rl[i]);
    end
    $display("test compare done");
    wr(4'h1, 8'h40);
    level <= 10'h2A4;
    wr(4'h0, 8'h01);
    chk(conv, 1'b0);
    pulse;
    repeat (4) @(posedge clk_in);
    chk(conv, 1'b1);
    pulse;
    poll;
    chk(f, 1'b1);
    repeat (10) @(posedge clk_in);
    chk(conv, 1'b0);
    rd(4'h2, 8'h02);
    rd(4'h3, 8'hA4);
    $display("test trigger done");
    wr(4'h1, 8'h00);
    level <= 10'h3FC;
    wr(4'h0, 8'h01);
    repeat (4) @(posedge clk_in);
    wr(4'h6, 8'h08);
    chk(conv, 1'b0);
    rd(4'h2, 8'h02);
    rd(4'h3, 8'hA4);
    wr(4'h0, 8'h01);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(conv, 1'b0);
    stop_mode <= 1'b0;
    $display("test abort done");
    // Half-bus, alternate and internal asynchronous clock sources, 10-bit single conversions.
    for (i = 1; i < 4; i++) begin
      wr(4'h6, {6'h02, i[1:0]});
      wr(4'h0, 8'h01);
      poll;
      chk(f, 1'b1);
      rd(4'h2, 8'h03);
      rd(4'h3, 8'hFC);
    end
    $display("test clocks done");
    tally_and_finish;
  end
endmodule
